// ===== rtl/sdf_pkg.sv
// Constants, types and helper functions of the sensor sample datapath and its byte FIFO.
//
// Contract
// - Each slot keeps positive and negative 32-bit unsigned sums that saturate, never wrap.
// - A sample goes to the negative sum by pulse negate select or by the dark region.
// - Impulse mode adds into the positive sum and writes it straight to the FIFO.
// - At slot end the signal is positive minus negative, clamped at zero, then decimated.
// - A ready decimated result updates data registers, writes the FIFO and sets the flag.
// - Downsample count plus one results are summed into one output, with no division.
// - Filter kind zero is block sum, others are CIC up to fourth order; dark is block sum.
// - Every slot owns its filter state; the decimation path is 32 bits and wraps freely.
// - The FIFO holds 256 bytes.
// - Reading an empty FIFO returns 0xff and sets the underrun flag.
// - Dark and signal each take zero to four bytes; zero omits the field.
// - Dark and signal are shifted right by zero to 31 bits before the FIFO.
// - A shifted value too wide for its byte count is written as all ones.
// - With both channels on, first-channel values go in before second-channel values.
// - No partial packet: if the period does not fit, nothing is written and overrun is set.
// - Within a slot entry the dark value comes before the signal value.
// - Byte order: 8 bit 7:0; 16 bit 15:8,7:0; 24 adds 23:16; 32 adds 31:24,23:16.
// - Signal and dark registers have an internal copy and a latched copy that software reads.
// - While hold is set only the internal copy updates; clearing hold resumes updates.
// - After all slots of a period the selected status bytes are appended.
// - The second channel works only in slots whose second path enable is set.
package sdf_pkg;

    localparam logic [11:0] SDF_CTRL_ADDR    = 12'h000;
    localparam logic [11:0] SDF_STATUS_ADDR  = 12'h004;
    localparam logic [11:0] SDF_FLAGS_ADDR   = 12'h008;
    localparam logic [11:0] SDF_FIFO_ADDR    = 12'h00c;
    localparam logic [3:0]  SDF_CFG_PAGE     = 4'h1;
    localparam logic [3:0]  SDF_DATA_PAGE    = 4'h2;

    localparam int SDF_FIFO_BYTES   = 256;
    localparam int SDF_SUM_W        = 32;
    localparam int SDF_CIC_MAX      = 4;
    localparam int SDF_STATUS_BYTES = 2;

    localparam int SDF_CFG_COUNT_LSB  = 0;
    localparam int SDF_CFG_KIND_LSB   = 8;
    localparam int SDF_CFG_DSHIFT_LSB = 11;
    localparam int SDF_CFG_SSHIFT_LSB = 16;
    localparam int SDF_CFG_DSIZE_LSB  = 21;
    localparam int SDF_CFG_SSIZE_LSB  = 24;
    localparam int SDF_CFG_HOLD_BIT   = 27;
    localparam int SDF_CFG_CH2_BIT    = 28;

    localparam int SDF_CTRL_MODE_LSB  = 0;
    localparam int SDF_CTRL_STAT_BIT  = 2;
    localparam int SDF_ST_UNDER_BIT   = 0;
    localparam int SDF_ST_OVER_BIT    = 1;
    localparam int SDF_ST_LEVEL_LSB   = 8;

    localparam logic [31:0] SDF_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SDF_CFG_RST  = 32'h0000_0000;
    localparam logic [7:0]  SDF_EMPTY_READ = 8'hff;

    typedef enum logic [1:0] {SDF_STANDARD, SDF_DIGINT, SDF_IMPULSE} sdf_mode_type;

    // Adds without wrapping; a carry pins the sum at its maximum.
    function automatic logic [31:0] sdf_sat_add(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[32] ? 32'hffff_ffff : s[31:0];
    endfunction : sdf_sat_add

    // Shifts right, drops the low bits and saturates to the byte count.
    function automatic logic [31:0] sdf_shape(input logic [31:0] v, input logic [4:0] sh,
                                              input logic [2:0] size);
        logic [31:0] s;
        logic [31:0] mask;
        s = v >> sh;
        mask = (size >= 3'h4) ? 32'hffff_ffff : ((32'h1 << {size, 3'h0}) - 32'h1);
        return ((s & ~mask) != 32'h0) ? mask : s;
    endfunction : sdf_shape

    function automatic logic [7:0] sdf_fifo_byte(input logic [31:0] v, input logic [2:0] size,
                                                 input logic [1:0] k);
        case (k)
            2'h0: return (size == 3'h1) ? v[7:0] : v[15:8];
            2'h1: return v[7:0];
            2'h2: return (size == 3'h3) ? v[23:16] : v[31:24];
            default: return v[23:16];
        endcase
    endfunction : sdf_fifo_byte

endpackage : sdf_pkg

// ===== rtl/sdf_datapath.sv
// Per-slot sample accumulation, decimation, result registers and packet FIFO behind APB.
`timescale 1ns/1ps
module sdf_datapath #(
    parameter int NUM_SLOTS = 12,
    parameter int ADC_W     = 14,
    parameter int SLOT_W    = 4
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sampleValid,
    input  wire logic                sampleChan,
    input  wire logic [SLOT_W-1:0]   sampleSlot,
    input  wire logic [ADC_W-1:0]    sampleData,
    input  wire logic                pulseNegateSelect,
    input  wire logic                sampleDarkRegion,
    input  wire logic                slotDone,
    input  wire logic                periodDone,
    output logic      [NUM_SLOTS-1:0] slotDataFlags
);

    typedef struct packed {
        logic [NUM_SLOTS-1:0][1:0][31:0]      sumPos;
        logic [NUM_SLOTS-1:0][1:0][31:0]      sumNeg;
        logic [NUM_SLOTS-1:0][1:0][3:0][31:0] integ;
        logic [NUM_SLOTS-1:0][1:0][3:0][31:0] comb;
        logic [NUM_SLOTS-1:0][1:0][31:0]      darkInteg;
        logic [NUM_SLOTS-1:0][1:0][31:0]      darkComb;
        logic [NUM_SLOTS-1:0][1:0][31:0]      sigInt;
        logic [NUM_SLOTS-1:0][1:0][31:0]      darkInt;
        logic [NUM_SLOTS-1:0][1:0][31:0]      sigLat;
        logic [NUM_SLOTS-1:0][1:0][31:0]      darkLat;
        logic [NUM_SLOTS-1:0][7:0]            decCnt;
        logic [NUM_SLOTS-1:0][31:0]           cfg;
        logic [31:0]                          ctrl;
        logic [sdf_pkg::SDF_FIFO_BYTES-1:0][7:0] mem;
        logic [7:0]                           rdPtr;
        logic [7:0]                           wrPtr;
        logic [8:0]                           count;
        logic [8:0]                           tent;
        logic                                 drop;
        logic                                 under;
        logic                                 over;
        logic                                 rdEmpty;
        logic                                 pready;
        logic                                 pslverr;
        logic [NUM_SLOTS-1:0]                 flags;
        logic [31:0]                          prdata;
    } sdf_state_type;

    sdf_state_type st_q;
    sdf_state_type st_d;

    logic apbAccess;
    logic apbDone;
    logic fifoRead;

    assign apbAccess = psel && penable;
    assign apbDone   = apbAccess && st_q.pready;
    assign fifoRead  = apbDone && !pwrite && (paddr == sdf_pkg::SDF_FIFO_ADDR);

    always_comb begin
        sdf_pkg::sdf_mode_type mode;
        logic [31:0]      c;
        logic [31:0]      x;
        logic [31:0]      y;
        logic [31:0]      dy;
        logic [31:0]      carry;
        logic [31:0]      rd;
        logic [31:0]      shaped;
        logic [15:0][7:0] pk;
        logic [4:0]       nb;
        logic [2:0]       order;
        logic [2:0]       dsz;
        logic [2:0]       ssz;
        logic [8:0]       freeSp;
        logic [9:0]       need;
        logic [8:0]       commitN;
        logic             pop;
        logic             toNeg;
        logic             ready;
        logic             err;
        int               s;
        int               idx;
        mode    = sdf_pkg::sdf_mode_type'(st_q.ctrl[sdf_pkg::SDF_CTRL_MODE_LSB +: 2]);
        c       = 32'h0;
        x       = 32'h0;
        y       = 32'h0;
        dy      = 32'h0;
        carry   = 32'h0;
        rd      = 32'h0;
        shaped  = 32'h0;
        pk      = '0;
        nb      = 5'h0;
        order   = 3'h1;
        dsz     = 3'h0;
        ssz     = 3'h0;
        freeSp  = 9'(sdf_pkg::SDF_FIFO_BYTES) - st_q.count;
        need    = 10'h0;
        commitN = 9'h0;
        pop     = 1'b0;
        toNeg   = 1'b0;
        ready   = 1'b0;
        err     = 1'b0;
        s       = int'(sampleSlot);
        idx     = 0;
        st_d    = st_q;

        // Register bus: the answer comes one cycle into the access phase so that prdata
        // and pslverr can be presented from flops.
        st_d.pready = apbAccess && !st_q.pready;
        if (apbAccess && !st_q.pready) begin
            case (paddr)
                sdf_pkg::SDF_CTRL_ADDR:   rd = st_q.ctrl;
                sdf_pkg::SDF_STATUS_ADDR: begin
                    rd[sdf_pkg::SDF_ST_UNDER_BIT] = st_q.under;
                    rd[sdf_pkg::SDF_ST_OVER_BIT]  = st_q.over;
                    rd[sdf_pkg::SDF_ST_LEVEL_LSB +: 9] = st_q.count;
                end
                sdf_pkg::SDF_FLAGS_ADDR:  rd = 32'(st_q.flags);
                sdf_pkg::SDF_FIFO_ADDR:   begin
                    rd = 32'(st_q.count == 9'h0 ? sdf_pkg::SDF_EMPTY_READ
                                                 : st_q.mem[st_q.rdPtr]);
                end
                default: begin
                    idx = int'(paddr[7:2]);
                    if (paddr[11:8] == sdf_pkg::SDF_CFG_PAGE && idx < NUM_SLOTS) begin
                        rd = st_q.cfg[idx];
                    end else if (paddr[11:8] == sdf_pkg::SDF_DATA_PAGE
                                 && int'(paddr[7:4]) < NUM_SLOTS) begin
                        idx = int'(paddr[7:4]);
                        case (paddr[3:2])
                            2'h0: rd = st_q.sigLat[idx][0];
                            2'h1: rd = st_q.darkLat[idx][0];
                            2'h2: rd = st_q.sigLat[idx][1];
                            default: rd = st_q.darkLat[idx][1];
                        endcase
                    end else begin
                        err = 1'b1;
                    end
                end
            endcase
            st_d.prdata  = rd;
            st_d.pslverr = err;
            st_d.rdEmpty = (st_q.count == 9'h0);
        end
        if (apbDone && pwrite) begin
            case (paddr)
                sdf_pkg::SDF_CTRL_ADDR:   st_d.ctrl = pwdata;
                sdf_pkg::SDF_STATUS_ADDR: begin
                    if (pwdata[sdf_pkg::SDF_ST_UNDER_BIT]) st_d.under = 1'b0;
                    if (pwdata[sdf_pkg::SDF_ST_OVER_BIT])  st_d.over  = 1'b0;
                end
                sdf_pkg::SDF_FLAGS_ADDR:  st_d.flags = st_q.flags & ~pwdata[NUM_SLOTS-1:0];
                default: begin
                    idx = int'(paddr[7:2]);
                    if (paddr[11:8] == sdf_pkg::SDF_CFG_PAGE && idx < NUM_SLOTS) begin
                        st_d.cfg[idx] = pwdata;
                    end
                end
            endcase
        end
        // The emptiness seen when the read was decoded decides its outcome, so the data
        // returned and the pop or underrun always agree.
        if (fifoRead) begin
            if (st_q.rdEmpty) begin
                st_d.under = 1'b1;
            end else begin
                st_d.rdPtr = st_q.rdPtr + 8'h1;
                pop = 1'b1;
            end
        end

        // Accumulation into the slot sums.
        if (sampleValid && s < NUM_SLOTS && !slotDone
            && (!sampleChan || st_q.cfg[s][sdf_pkg::SDF_CFG_CH2_BIT])) begin
            case (mode)
                sdf_pkg::SDF_STANDARD: toNeg = pulseNegateSelect;
                sdf_pkg::SDF_DIGINT:   toNeg = sampleDarkRegion;
                default:               toNeg = 1'b0;
            endcase
            if (toNeg) begin
                st_d.sumNeg[s][sampleChan] = sdf_pkg::sdf_sat_add(
                    st_q.sumNeg[s][sampleChan], 32'(sampleData));
            end else begin
                st_d.sumPos[s][sampleChan] = sdf_pkg::sdf_sat_add(
                    st_q.sumPos[s][sampleChan], 32'(sampleData));
            end
        end

        // End of a slot: form, decimate, latch and stage the slot's FIFO bytes.
        if (slotDone && s < NUM_SLOTS) begin
            c     = st_q.cfg[s];
            dsz   = (c[sdf_pkg::SDF_CFG_DSIZE_LSB +: 3] > 3'h4) ? 3'h4
                                                              : c[sdf_pkg::SDF_CFG_DSIZE_LSB +: 3];
            ssz   = (c[sdf_pkg::SDF_CFG_SSIZE_LSB +: 3] > 3'h4) ? 3'h4
                                                              : c[sdf_pkg::SDF_CFG_SSIZE_LSB +: 3];
            order = (c[sdf_pkg::SDF_CFG_KIND_LSB +: 3] >= 3'h3) ? 3'(sdf_pkg::SDF_CIC_MAX)
                                                      : c[sdf_pkg::SDF_CFG_KIND_LSB +: 3] + 3'h1;
            ready = (st_q.decCnt[s] == c[sdf_pkg::SDF_CFG_COUNT_LSB +: 8]);
            if (mode == sdf_pkg::SDF_IMPULSE) begin
                for (int k = 0; k < 4; k++) begin
                    pk[k] = sdf_pkg::sdf_fifo_byte(st_q.sumPos[s][0], 3'h4, 2'(k));
                end
                nb = 5'h4;
            end else begin
                for (int ch = 0; ch < 2; ch++) begin
                    if (ch == 0 || c[sdf_pkg::SDF_CFG_CH2_BIT]) begin
                        x = (st_q.sumPos[s][ch] > st_q.sumNeg[s][ch])
                            ? st_q.sumPos[s][ch] - st_q.sumNeg[s][ch] : 32'h0;
                        // Integrators run every slot result; combs only at the output rate.
                        carry = x;
                        for (int k = 0; k < sdf_pkg::SDF_CIC_MAX; k++) begin
                            st_d.integ[s][ch][k] = st_q.integ[s][ch][k] + carry;
                            carry = st_d.integ[s][ch][k];
                        end
                        st_d.darkInteg[s][ch] = st_q.darkInteg[s][ch] + st_q.sumNeg[s][ch];
                        if (ready) begin
                            y = st_d.integ[s][ch][order - 3'h1];
                            for (int k = 0; k < sdf_pkg::SDF_CIC_MAX; k++) begin
                                if (k < int'(order)) begin
                                    dy = y - st_q.comb[s][ch][k];
                                    st_d.comb[s][ch][k] = y;
                                    y = dy;
                                end
                            end
                            st_d.sigInt[s][ch]   = y;
                            st_d.darkInt[s][ch]  = st_d.darkInteg[s][ch]
                                                   - st_q.darkComb[s][ch];
                            st_d.darkComb[s][ch] = st_d.darkInteg[s][ch];
                            shaped = sdf_pkg::sdf_shape(st_d.darkInt[s][ch],
                                         c[sdf_pkg::SDF_CFG_DSHIFT_LSB +: 5], dsz);
                            for (int k = 0; k < 4; k++) begin
                                if (k < int'(dsz)) begin
                                    pk[nb] = sdf_pkg::sdf_fifo_byte(shaped, dsz, 2'(k));
                                    nb = nb + 5'h1;
                                end
                            end
                            shaped = sdf_pkg::sdf_shape(st_d.sigInt[s][ch],
                                         c[sdf_pkg::SDF_CFG_SSHIFT_LSB +: 5], ssz);
                            for (int k = 0; k < 4; k++) begin
                                if (k < int'(ssz)) begin
                                    pk[nb] = sdf_pkg::sdf_fifo_byte(shaped, ssz, 2'(k));
                                    nb = nb + 5'h1;
                                end
                            end
                        end
                    end
                end
                if (ready) begin
                    st_d.flags[s]  = 1'b1;
                    st_d.decCnt[s] = 8'h0;
                end else begin
                    st_d.decCnt[s] = st_q.decCnt[s] + 8'h1;
                end
            end
            st_d.sumPos[s] = '0;
            st_d.sumNeg[s] = '0;
            // Bytes land past the committed level; the reader cannot see them until the
            // period commits, which is what keeps packets whole.
            need = {1'b0, st_q.tent} + 10'(nb);
            if (!st_q.drop && need <= {1'b0, freeSp}) begin
                for (int k = 0; k < 16; k++) begin
                    if (k < int'(nb)) begin
                        st_d.mem[8'(st_q.wrPtr + st_q.tent[7:0] + 8'(k))] = pk[k];
                    end
                end
                st_d.tent = need[8:0];
            end else if (nb != 5'h0) begin
                st_d.drop = 1'b1;
            end
        end

        // End of the period: append status bytes and commit, or drop everything.
        if (periodDone) begin
            need = {1'b0, st_q.tent}
                 + (st_q.ctrl[sdf_pkg::SDF_CTRL_STAT_BIT] ? 10'(sdf_pkg::SDF_STATUS_BYTES) : 10'h0);
            if (!st_q.drop && need <= {1'b0, freeSp}) begin
                if (st_q.ctrl[sdf_pkg::SDF_CTRL_STAT_BIT]) begin
                    st_d.mem[8'(st_q.wrPtr + st_q.tent[7:0])] = 8'(st_q.flags);
                    st_d.mem[8'(st_q.wrPtr + st_q.tent[7:0] + 8'h1)] =
                        8'(32'(st_q.flags) >> 8);
                end
                commitN    = need[8:0];
                st_d.wrPtr = st_q.wrPtr + need[7:0];
            end else begin
                // A dropped slot spoils the period even when nothing else was staged.
                st_d.over = 1'b1;
            end
            st_d.tent = 9'h0;
            st_d.drop = 1'b0;
        end
        st_d.count = st_q.count + commitN - {8'h0, pop};

        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (!st_q.cfg[i][sdf_pkg::SDF_CFG_HOLD_BIT]) begin
                st_d.sigLat[i]  = st_d.sigInt[i];
                st_d.darkLat[i] = st_d.darkInt[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q      <= '0;
            st_q.ctrl <= sdf_pkg::SDF_CTRL_RST;
            st_q.cfg  <= {NUM_SLOTS{sdf_pkg::SDF_CFG_RST}};
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata        = st_q.prdata;
    assign pready        = st_q.pready;
    assign pslverr       = st_q.pslverr;
    assign slotDataFlags = st_q.flags;

    logic fifoFull;
    assign fifoFull = (st_q.count == 9'(sdf_pkg::SDF_FIFO_BYTES));

    sum_saturate_a: assert property (@(posedge clk) disable iff (srst)
        st_q.sumPos[0][0] == 32'hffff_ffff && !slotDone |=> st_q.sumPos[0][0] == 32'hffff_ffff)
        else $error("positive sum left saturation");
    negate_route_a: assert property (@(posedge clk) disable iff (srst)
        sampleValid && !sampleChan && sampleSlot == '0 && pulseNegateSelect && !slotDone
        && st_q.ctrl[1:0] == 2'h0 |=> $stable(st_q.sumPos[0][0]))
        else $error("negated sample reached positive sum");
    clamp_zero_a: assert property (@(posedge clk) disable iff (srst)
        slotDone && sampleSlot == '0 && st_q.ctrl[1:0] == 2'h0 && st_q.cfg[0][10:0] == 11'h0
        && st_q.sumNeg[0][0] >= st_q.sumPos[0][0] && !$past(srst)
        && st_q.integ[0][0][0] == st_q.comb[0][0][0] |=> st_q.sigInt[0][0] == 32'h0)
        else $error("negative signal was not clamped");
    flag_cause_a: assert property (@(posedge clk) disable iff (srst)
        $rose(st_q.flags[0]) |-> $past(slotDone && sampleSlot == '0))
        else $error("data flag set without a slot result");
    fifo_bound_a: assert property (@(posedge clk) disable iff (srst)
        st_q.count <= 9'(sdf_pkg::SDF_FIFO_BYTES))
        else $error("fifo level above capacity");
    underrun_a: assert property (@(posedge clk) disable iff (srst)
        fifoRead && st_q.rdEmpty |-> prdata == 32'h0000_00ff ##1 st_q.under)
        else $error("empty read mishandled");
    whole_packet_a: assert property (@(posedge clk) disable iff (srst)
        st_q.count > $past(st_q.count) |-> $past(periodDone))
        else $error("fifo grew outside a period commit");
    hold_latch_a: assert property (@(posedge clk) disable iff (srst)
        st_q.cfg[0][sdf_pkg::SDF_CFG_HOLD_BIT] [*2] |-> $stable(st_q.sigLat[0][0]))
        else $error("held latch changed");
    pop_oldest_a: assert property (@(posedge clk) disable iff (srst)
        fifoRead && !st_q.rdEmpty |=> st_q.rdPtr == $past(st_q.rdPtr) + 8'h1)
        else $error("read did not remove a byte");

    fill_c: cover property (@(posedge clk) disable iff (srst) fifoFull);
    overrun_c: cover property (@(posedge clk) disable iff (srst) $rose(st_q.over));
    decimate_c: cover property (@(posedge clk) disable iff (srst)
        $rose(st_q.flags[0]) && st_q.cfg[0][7:0] != 8'h0);

endmodule : sdf_datapath

// ===== bench/sdf_host.sv
// Host model: APB master that reads and writes the datapath registers.
`timescale 1ns/1ps
module sdf_host (
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    logic hung = 1'b0;
    logic lastErr = 1'b0;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // The request is held until pready is seen high; after 50 cycles without it the host flags a hang.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        lastErr = pslverr;
        hung = (n >= 50);
        {psel, penable} <= 2'b00;
    endtask : xfer
endmodule : sdf_host

// ===== bench/testbench.sv
// Self-checking bench for the sample datapath and its byte FIFO.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, srst = 1'b1, sampleValid = 1'b0, pulseNegateSelect = 1'b0;
    logic slotDone = 1'b0, periodDone = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [3:0] sampleSlot = 4'h0;
    logic [13:0] sampleData = 14'h0000;
    logic [11:0] paddr, slotDataFlags;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] expBytes [4] = '{8'h1e, 8'h00, 8'h78, 8'hff};
    logic [7:0] impBytes [4] = '{8'h00, 8'h96, 8'h00, 8'h00};
    int miscompares = 0, comparisons = 0;
    always #50 clk = ~clk;
    sdf_host i_host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    sdf_datapath i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleValid(sampleValid), .sampleChan(1'b0),
        .sampleSlot(sampleSlot), .sampleData(sampleData),
        .pulseNegateSelect(pulseNegateSelect), .sampleDarkRegion(1'b0),
        .slotDone(slotDone), .periodDone(periodDone), .slotDataFlags(slotDataFlags));
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    always @(posedge clk) if (i_host.hung === 1'b1) begin
        miscompares++;
        print_verdict();
    end
    task automatic chk(input logic [11:0] a, input logic [31:0] e);
        i_host.xfer(1'b0, a, 32'h0, rd);
        comparisons++;
        if (rd !== e) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, rd, e);
        end
        if (i_host.lastErr !== 1'b0) begin
            miscompares++;
            $display("ERROR t=%0t pslverr got %h exp %h", $time, i_host.lastErr, 1'b0);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, rd);
    endtask : wr
    task automatic smp(input logic [3:0] s, input logic [13:0] d, input logic neg);
        @(posedge clk);
        {sampleValid, sampleSlot, sampleData, pulseNegateSelect} <= {1'b1, s, d, neg};
        @(posedge clk);
        sampleValid <= 1'b0;
    endtask : smp
    task automatic ev(input logic [3:0] s, input logic per);
        @(posedge clk);
        {slotDone, periodDone, sampleSlot} <= {~per, per, s};
        @(posedge clk);
        {slotDone, periodDone} <= 2'b00;
    endtask : ev
    // Slot 0 ends with signal 120 and dark 30, slot 1 with signal 300.
    task automatic period();
        smp(4'h0, 14'h0064, 1'b0);
        smp(4'h0, 14'h0032, 1'b0);
        smp(4'h0, 14'h001e, 1'b1);
        ev(4'h0, 1'b0);
        smp(4'h1, 14'h012c, 1'b0);
        ev(4'h1, 1'b0);
        ev(4'h0, 1'b1);
    endtask : period
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(12'h000, 32'h0000_0000);
        chk(12'h00c, 32'h0000_00ff);
        chk(12'h004, 32'h0000_0001);
        wr(12'h004, 32'h0000_0003);
        wr(12'h100, 32'h0220_0000);
        wr(12'h104, 32'h0100_0000);
        period();
        chk(12'h004, 32'h0000_0400);
        chk(12'h008, 32'h0000_0003);
        comparisons++;
        if (slotDataFlags !== 12'h003) begin
            miscompares++;
            $display("ERROR t=%0t flags got %h exp %h", $time, slotDataFlags, 12'h003);
        end
        chk(12'h200, 32'h0000_0078);
        chk(12'h204, 32'h0000_001e);
        chk(12'h210, 32'h0000_012c);
        foreach (expBytes[i]) chk(12'h00c, {24'h0, expBytes[i]});
        chk(12'h00c, 32'h0000_00ff);
        // Impulse mode ignores the negate select and sends the raw 32-bit positive sum.
        wr(12'h000, 32'h0000_0002);
        smp(4'h0, 14'h0064, 1'b1);
        smp(4'h0, 14'h0032, 1'b0);
        ev(4'h0, 1'b0);
        ev(4'h0, 1'b1);
        foreach (impBytes[i]) chk(12'h00c, {24'h0, impBytes[i]});
        wr(12'h000, 32'h0000_0000);
        wr(12'h004, 32'h0000_0003);
        repeat (64) period();
        chk(12'h004, 32'h0001_0000);
        period();
        chk(12'h004, 32'h0001_0002);
        chk(12'h00c, 32'h0000_001e);
        // A held slot keeps its old latch; a dark-only slot clamps its signal to zero.
        wr(12'h100, 32'h0a20_0000);
        smp(4'h0, 14'h0010, 1'b1);
        ev(4'h0, 1'b0);
        chk(12'h200, 32'h0000_0078);
        wr(12'h100, 32'h0220_0000);
        chk(12'h200, 32'h0000_0000);
        chk(12'h204, 32'h0000_0010);
        print_verdict();
    end
endmodule : testbench
